/* pek_pkg.sv */
// Purpose: shared constants for the program error recorder
// Assumes: APB with 32-bit data, word aligned registers
// Notes:   bit positions follow the fault status word layout
package pek_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FAULT_STATUS   = 8'h00;
    localparam logic [7:0] OFS_IRQ_MASK       = 8'h04;
    localparam logic [7:0] OFS_CONTROL        = 8'h08;
    localparam logic [7:0] OFS_STOPPED_TASK   = 8'h0C;
    localparam logic [7:0] OFS_ADDR_LOW       = 8'h10;
    localparam logic [7:0] OFS_ADDR_HIGH      = 8'h14;
    localparam logic [7:0] OFS_FLAGS          = 8'h18;
    localparam logic [7:0] OFS_DIFF_COUNT     = 8'h1C;
    // Fault status bit positions
    localparam int BIT_PROC_ERR    = 8;
    localparam int BIT_IND_BCD     = 9;
    localparam int BIT_ILL_ACCESS  = 10;
    localparam int BIT_NO_END      = 11;
    localparam int BIT_TASK_ERR    = 12;
    localparam int BIT_DIFF_OVF    = 13;
    localparam int BIT_ILL_INSTR   = 14;
    localparam int BIT_UM_OVF      = 15;
    // Control bit positions
    localparam int CTL_PROC_FATAL  = 0;
    localparam int CTL_ACC_FATAL   = 1;
    localparam int CTL_BCD_MODE    = 2;
    localparam int CTL_RUN_REQ     = 3;
    // Flag word bit positions
    localparam int FLG_INSTR_ERR   = 0;
    localparam int FLG_ACCESS_ERR  = 1;
    localparam int FLG_HALTED      = 2;
    // Reset values
    localparam logic [15:0] RST_WORD     = 16'h0000;
    localparam logic [3:0]  RST_CONTROL  = 4'h0;
    // Task number encoding
    localparam logic [15:0] TASK_INT_BASE  = 16'h8000;
    localparam logic [15:0] TASK_CYC_MAX   = 16'h001F;
    localparam logic [15:0] TASK_INT_MAX   = 16'h80FF;
    // Differentiation edit limit
    localparam int          DIFF_LIMIT     = 31072;
    // Halt state machine
    typedef enum logic [1:0] {
        PEK_RUN    = 2'b00,
        PEK_HALT   = 2'b01
    } pek_state_e;
endpackage : pek_pkg

/* pek_bcd_check.sv */
// Purpose: flags a 16-bit word holding any non-decimal nibble
// Assumes: pointer word presented combinationally
// Notes:   one instance per checked word
`timescale 1ns/1ps
`default_nettype none
module pek_bcd_check #(
    parameter int DIGITS = 4
) (
    // Word under test
    input  wire logic [4*DIGITS-1:0] word,
    // Result
    output logic                     notBcd
);
    logic [DIGITS-1:0] digitBad;
    genvar g;
    generate
        for (g = 0; g < DIGITS; g++) begin : gDigit
            assign digitBad[g] = (word[4*g+3 -: 4] > 4'h9);
        end
    endgenerate
    assign notBcd = |digitBad;
endmodule : pek_bcd_check
`default_nettype wire

/* pek_ir_update.sv */
// Purpose: index register auto increment and decrement
// Assumes: step of one or two per executed instruction
// Notes:   update is independent of error outcome
`timescale 1ns/1ps
`default_nettype none
module pek_ir_update #(
    parameter int WIDTH = 32
) (
    // Current value and mode
    input  wire logic [WIDTH-1:0] irValue,
    input  wire logic             incEn,
    input  wire logic             decEn,
    input  wire logic             stepTwo,
    // Updated value
    output logic      [WIDTH-1:0] irNext
);
    wire logic [WIDTH-1:0] step;
    assign step   = stepTwo ? WIDTH'(2) : WIDTH'(1);
    assign irNext = incEn ? irValue + step : (decEn ? irValue - step : irValue);
endmodule : pek_ir_update
`default_nettype wire

/* pek_error_recorder.sv */
// Purpose: classify run time program faults, record them, halt execution
// Assumes: engine pulses are one cycle, synchronous to mclk
// Notes:   registers reached over APB; one level interrupt
//
// How it works
// RQ1: Operand error sets instruction flag; fatal setting adds status bit and halt.
// RQ2: Access error sets access flag; fatal setting adds access, BCD bits, halt.
// RQ3: Unexecutable instruction sets its status bit and always halts.
// RQ4: Running past program memory end sets overflow bit and halts.
// RQ5: Halt stores task number: cyclic 0000-001F, interrupt 8000-80FF.
// RQ6: Halt stores program address, upper half high word, lower half low word.
// RQ7: Missing end instruction sets its bit and counts as program error.
// RQ8: Task error bit for no cyclic task, empty task, missing interrupt task.
// RQ9: Access error detected from five distinct causes.
// RQ10: Non-BCD pointer in BCD mode sets access flag and BCD bit.
// RQ11: Too many differentiated online edits set the overflow bit.
// RQ12: Index register auto update happens even when an error flag rises.
// RQ13: Status words hold until software clear or reset; captured words hold until the next halt or reset.
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pek_error_recorder #(
    parameter int IR_WIDTH   = 32,
    parameter int DIFF_MAX   = pek_pkg::DIFF_LIMIT
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Execution engine events
    input  wire logic                 instrExec,
    input  wire logic                 operandErr,
    input  wire logic                 paramAreaAccess,
    input  wire logic                 uninstalledWrite,
    input  wire logic                 fileBankAccess,
    input  wire logic                 readOnlyWrite,
    input  wire logic                 indirectUse,
    input  wire logic [15:0]          pointerWord,
    input  wire logic                 illegalInstr,
    input  wire logic                 umOverflow,
    input  wire logic                 noEndInstr,
    input  wire logic                 noCyclicTask,
    input  wire logic                 taskNoProgram,
    input  wire logic                 missingIntTask,
    input  wire logic                 diffEdit,
    // Engine context
    input  wire logic                 taskIsInterrupt,
    input  wire logic [7:0]           taskIndex,
    input  wire logic [31:0]          programAddr,
    // Index register port
    input  wire logic [IR_WIDTH-1:0]  irValue,
    input  wire logic                 irInc,
    input  wire logic                 irDec,
    input  wire logic                 irStepTwo,
    output logic      [IR_WIDTH-1:0]  irNext,
    // Status to engine
    output logic                      haltExec,
    output logic                      instructionErrorFlag,
    output logic                      accessErrorFlag,
    output logic                      irq
);
    logic [15:0]         faultStatus_q;
    logic [15:0]         faultStatus_d;
    logic [15:0]         irqMask_q;
    logic [3:0]          control_q;
    logic [15:0]         stoppedTask_q;
    logic [15:0]         addrLow_q;
    logic [15:0]         addrHigh_q;
    logic                instrFlag_q;
    logic                accFlag_q;
    logic [16:0]         diffCount_q;
    pek_pkg::pek_state_e state_q;
    pek_pkg::pek_state_e state_d;

    // APB decode
    wire logic           apbWrite;
    wire logic           apbRead;
    wire logic           hitStatus;
    wire logic           hitMask;
    wire logic           hitControl;
    wire logic           hitMapped;
    assign apbWrite   = psel && penable && pwrite;
    assign apbRead    = psel && penable && !pwrite;
    assign hitStatus  = (paddr == pek_pkg::OFS_FAULT_STATUS);
    assign hitMask    = (paddr == pek_pkg::OFS_IRQ_MASK);
    assign hitControl = (paddr == pek_pkg::OFS_CONTROL);
    assign hitMapped  = hitStatus || hitMask || hitControl
                        || (paddr == pek_pkg::OFS_STOPPED_TASK)
                        || (paddr == pek_pkg::OFS_ADDR_LOW)
                        || (paddr == pek_pkg::OFS_ADDR_HIGH)
                        || (paddr == pek_pkg::OFS_FLAGS)
                        || (paddr == pek_pkg::OFS_DIFF_COUNT);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hitMapped;

    // Configuration bits
    wire logic procFatal;
    wire logic accFatal;
    wire logic bcdMode;
    assign procFatal = control_q[pek_pkg::CTL_PROC_FATAL];
    assign accFatal  = control_q[pek_pkg::CTL_ACC_FATAL];
    assign bcdMode   = control_q[pek_pkg::CTL_BCD_MODE];

    // RQ10: pointer digit check
    wire logic pointerNotBcd;
    pek_bcd_check #(
        .DIGITS (4)
    ) uBcd (
        .word   (pointerWord),
        .notBcd (pointerNotBcd)
    );
    wire logic bcdErr;
    assign bcdErr = indirectUse && bcdMode && pointerNotBcd;

    // RQ9: five access causes
    wire logic accessErr;
    assign accessErr = paramAreaAccess || uninstalledWrite || fileBankAccess
                       || readOnlyWrite || bcdErr;

    // RQ8: task error causes
    wire logic taskErr;
    assign taskErr = noCyclicTask || taskNoProgram || missingIntTask;

    // RQ11: edit counter limit
    wire logic diffOvf;
    assign diffOvf = diffEdit && (diffCount_q >= 17'(DIFF_MAX));

    // Fatal event collection
    wire logic procFatalEv;
    wire logic accFatalEv;
    wire logic stopEv;
    assign procFatalEv = operandErr && procFatal;
    assign accFatalEv  = accessErr && accFatal;
    // RQ3: halt causes, the always halting faults plus fatal operand and access errors
    assign stopEv = procFatalEv || accFatalEv || illegalInstr || umOverflow
                    || noEndInstr || taskErr || diffOvf;

    // Status set mask
    logic [15:0] setBits;
    always_comb begin
        setBits = 16'h0000;
        // RQ1: fatal operand error bit
        setBits[pek_pkg::BIT_PROC_ERR]   = procFatalEv;
        // RQ2: fatal access bits
        setBits[pek_pkg::BIT_ILL_ACCESS] = accFatalEv;
        setBits[pek_pkg::BIT_IND_BCD]    = accFatalEv || bcdErr;
        setBits[pek_pkg::BIT_ILL_INSTR]  = illegalInstr;
        // RQ4: memory end overflow
        setBits[pek_pkg::BIT_UM_OVF]     = umOverflow;
        // RQ7: missing end bit
        setBits[pek_pkg::BIT_NO_END]     = noEndInstr;
        setBits[pek_pkg::BIT_TASK_ERR]   = taskErr;
        setBits[pek_pkg::BIT_DIFF_OVF]   = diffOvf;
    end

    // RQ13: write one to clear, set wins
    wire logic [15:0] clrBits;
    assign clrBits       = (apbWrite && hitStatus) ? pwdata[15:0] : 16'h0000;
    assign faultStatus_d = (faultStatus_q & ~clrBits) | setBits;

    // Halt machine: stays halted until software run request
    wire logic runReq;
    assign runReq = apbWrite && hitControl && pwdata[pek_pkg::CTL_RUN_REQ];
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            pek_pkg::PEK_RUN:  if (stopEv) state_d = pek_pkg::PEK_HALT;
            pek_pkg::PEK_HALT: if (runReq && !stopEv) state_d = pek_pkg::PEK_RUN;
        endcase
    end
    wire logic capture;
    assign capture = stopEv && (state_q == pek_pkg::PEK_RUN);

    // RQ5: task number encoding
    wire logic [15:0] taskCode;
    assign taskCode = taskIsInterrupt ? (pek_pkg::TASK_INT_BASE | {8'h00, taskIndex})
                                      : {11'h000, taskIndex[4:0]};

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q       <= pek_pkg::PEK_RUN;
            faultStatus_q <= pek_pkg::RST_WORD;
        end else begin
            state_q       <= state_d;
            faultStatus_q <= faultStatus_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irqMask_q <= pek_pkg::RST_WORD;
            control_q <= pek_pkg::RST_CONTROL;
        end else begin
            if (apbWrite && hitMask) irqMask_q <= pwdata[15:0];
            if (apbWrite && hitControl) control_q <= {1'b0, pwdata[2:0]};
        end
    end

    // RQ6: capture address halves
    always_ff @(posedge mclk) begin
        if (rst) begin
            stoppedTask_q <= pek_pkg::RST_WORD;
            addrLow_q     <= pek_pkg::RST_WORD;
            addrHigh_q    <= pek_pkg::RST_WORD;
        end else if (capture) begin
            stoppedTask_q <= taskCode;
            addrLow_q     <= programAddr[15:0];
            addrHigh_q    <= programAddr[31:16];
        end
    end

    // RQ1: sticky error flags, write one clears
    wire logic flagClr;
    assign flagClr = apbWrite && (paddr == pek_pkg::OFS_FLAGS);
    always_ff @(posedge mclk) begin
        if (rst) begin
            instrFlag_q <= 1'b0;
            accFlag_q   <= 1'b0;
        end else begin
            instrFlag_q <= operandErr
                           || (instrFlag_q && !(flagClr && pwdata[pek_pkg::FLG_INSTR_ERR]));
            // RQ2: access flag set
            accFlag_q   <= accessErr
                           || (accFlag_q && !(flagClr && pwdata[pek_pkg::FLG_ACCESS_ERR]));
        end
    end

    // RQ11: edit counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            diffCount_q <= 17'h00000;
        end else if (diffEdit && !diffOvf) begin
            diffCount_q <= diffCount_q + 17'h00001;
        end
    end

    // RQ12: index register update regardless of error
    pek_ir_update #(
        .WIDTH   (IR_WIDTH)
    ) uIr (
        .irValue (irValue),
        .incEn   (instrExec && irInc),
        .decEn   (instrExec && irDec),
        .stepTwo (irStepTwo),
        .irNext  (irNext)
    );

    // Read mux
    always_comb begin
        prdata = 32'h00000000;
        if (apbRead) begin
            unique case (paddr)
                pek_pkg::OFS_FAULT_STATUS: prdata = {16'h0000, faultStatus_q};
                pek_pkg::OFS_IRQ_MASK:     prdata = {16'h0000, irqMask_q};
                pek_pkg::OFS_CONTROL:      prdata = {28'h0000000, 1'b0, control_q[2:0]};
                pek_pkg::OFS_STOPPED_TASK: prdata = {16'h0000, stoppedTask_q};
                pek_pkg::OFS_ADDR_LOW:     prdata = {16'h0000, addrLow_q};
                pek_pkg::OFS_ADDR_HIGH:    prdata = {16'h0000, addrHigh_q};
                pek_pkg::OFS_FLAGS:        prdata = {29'h00000000, haltExec, accFlag_q, instrFlag_q};
                pek_pkg::OFS_DIFF_COUNT:   prdata = {15'h0000, diffCount_q};
                default:                   prdata = 32'h00000000;
            endcase
        end
    end

    assign haltExec             = (state_q == pek_pkg::PEK_HALT);
    assign instructionErrorFlag = instrFlag_q;
    assign accessErrorFlag      = accFlag_q;
    // Level interrupt from unmasked sticky bits
    assign irq = |(faultStatus_q & irqMask_q);

    // Assertions
    AST_FATAL_OPERAND: assert property (@(posedge mclk) disable iff (rst) // RQ1
        operandErr && procFatal && !haltExec |=> haltExec && faultStatus_q[pek_pkg::BIT_PROC_ERR])
        else $error("fatal operand error did not halt");
    AST_NONFATAL_OPERAND: assert property (@(posedge mclk) disable iff (rst) // RQ1
        operandErr |=> instrFlag_q)
        else $error("instruction error flag not raised");
    AST_FATAL_ACCESS: assert property (@(posedge mclk) disable iff (rst) // RQ2
        accessErr && accFatal |=> faultStatus_q[pek_pkg::BIT_ILL_ACCESS] && faultStatus_q[pek_pkg::BIT_IND_BCD] && haltExec)
        else $error("fatal access bits missing");
    AST_ILL_INSTR: assert property (@(posedge mclk) disable iff (rst) // RQ3
        illegalInstr |=> haltExec && faultStatus_q[pek_pkg::BIT_ILL_INSTR])
        else $error("illegal instruction did not halt");
    AST_UM_OVF: assert property (@(posedge mclk) disable iff (rst) // RQ4
        umOverflow |=> haltExec && faultStatus_q[pek_pkg::BIT_UM_OVF])
        else $error("overflow did not halt");
    AST_TASK_CODE: assert property (@(posedge mclk) disable iff (rst) // RQ5
        capture && taskIsInterrupt |=> stoppedTask_q == (pek_pkg::TASK_INT_BASE | {8'h00, $past(taskIndex)}))
        else $error("interrupt task code wrong");
    AST_ADDR_SPLIT: assert property (@(posedge mclk) disable iff (rst) // RQ6
        capture |=> addrHigh_q == $past(programAddr[31:16]) && addrLow_q == $past(programAddr[15:0]))
        else $error("program address capture wrong");
    AST_NO_END: assert property (@(posedge mclk) disable iff (rst) // RQ7
        noEndInstr |=> haltExec && faultStatus_q[pek_pkg::BIT_NO_END])
        else $error("missing end not recorded");
    AST_TASK_ERR: assert property (@(posedge mclk) disable iff (rst) // RQ8
        taskNoProgram |=> faultStatus_q[pek_pkg::BIT_TASK_ERR])
        else $error("task error not recorded");
    AST_ACCESS_CAUSE: assert property (@(posedge mclk) disable iff (rst) // RQ9
        readOnlyWrite ##1 !flagClr |=> accFlag_q)
        else $error("read only write missed");
    AST_BCD_PTR: assert property (@(posedge mclk) disable iff (rst) // RQ10
        indirectUse && bcdMode && pointerWord == 16'h00A0 |=> faultStatus_q[pek_pkg::BIT_IND_BCD])
        else $error("non decimal pointer missed");
    AST_DIFF_OVF: assert property (@(posedge mclk) disable iff (rst) // RQ11
        diffEdit && diffCount_q < 17'(DIFF_MAX) |=> !faultStatus_q[pek_pkg::BIT_DIFF_OVF] || $past(faultStatus_q[pek_pkg::BIT_DIFF_OVF]))
        else $error("overflow set below limit");
    AST_IR_UPDATE: assert property (@(posedge mclk) disable iff (rst) // RQ12
        instrExec && irInc && !irDec && operandErr |-> irNext != irValue)
        else $error("index register not updated on error");
    AST_HOLD: assert property (@(posedge mclk) disable iff (rst) // RQ13
        !capture ##1 !capture |-> stoppedTask_q == $past(stoppedTask_q))
        else $error("captured task changed without halt");
    // Halt entry and exit steps
    sequence s_stopInRun;
        stopEv && !haltExec;
    endsequence
    sequence s_haltedResume;
        haltExec && runReq && !stopEv;
    endsequence
    AST_CYCLIC_CODE: assert property (@(posedge mclk) disable iff (rst) // RQ5
        capture && !taskIsInterrupt |=> stoppedTask_q == {11'h000, $past(taskIndex[4:0])})
        else $error("cyclic task code wrong");
    AST_STOP_HALTS: assert property (@(posedge mclk) disable iff (rst) // RQ8
        s_stopInRun |=> haltExec)
        else $error("stop event did not halt");
    AST_RESUME: assert property (@(posedge mclk) disable iff (rst) // RQ13
        s_haltedResume |=> !haltExec)
        else $error("run request did not resume");
    AST_HALT_HOLD: assert property (@(posedge mclk) disable iff (rst) // RQ13
        haltExec && !runReq |=> haltExec)
        else $error("halt released without run request");
    AST_STATUS_HOLD: assert property (@(posedge mclk) disable iff (rst) // RQ13
        !(apbWrite && hitStatus) |=> (faultStatus_q & $past(faultStatus_q)) == $past(faultStatus_q))
        else $error("status bit dropped without clear");
    AST_PARAM_ACCESS: assert property (@(posedge mclk) disable iff (rst) // RQ9
        paramAreaAccess |=> accFlag_q)
        else $error("parameter area access missed");
endmodule : pek_error_recorder
`default_nettype wire

/* pek_engine_model.sv */
// Purpose: behavioural execution engine that raises fault events
// Assumes: one command per request, registered one cycle later
// Notes:   code 13 is a plain executed instruction with no fault
`timescale 1ns/1ps
`default_nettype none
module pek_engine_model (
    // Clock, reset, halt feedback
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        haltExec,
    // Command from the bench
    input  wire logic        fire,
    input  wire logic [3:0]  code,
    // Event pulses to the recorder
    output logic             instrExec,
    output logic      [12:0] evt
);
    logic [12:0] evt_q;
    logic [12:0] evt_d;
    logic        exec_q;
    logic        exec_d;

    // One-hot, so two faults never share a cycle by accident
    assign evt_d  = fire ? (13'h0001 << code) : 13'h0000;
    // executed instruction
    // Halted engine executes nothing; codes 0-5 still execute despite their fault, codes 6-12 do not
    assign exec_d = fire && (code <= 4'h5 || code == 4'hD) && !haltExec;

    always_ff @(posedge mclk) begin
        if (rst) begin
            evt_q  <= 13'h0000;
            exec_q <= 1'b0;
        end else begin
            evt_q  <= evt_d;
            exec_q <= exec_d;
        end
    end

    assign evt       = evt_q;
    assign instrExec = exec_q;
endmodule : pek_engine_model
`default_nettype wire

/* test_program_error_recorder.sv */
// Purpose: self-checking bench for the program error recorder
// Assumes: zero wait APB slave, one-cycle engine pulses
// Notes:   edit limit shortened to 4 for a short run
`timescale 1ns/1ps
`default_nettype none
module test_program_error_recorder;
    localparam int DMAX = 4;
    logic        mclk    = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic        fire    = 1'b0;
    logic [3:0]  code    = 4'h0;
    logic        isInt   = 1'b0;
    logic [7:0]  tIdx    = 8'h00;
    logic [31:0] pAddr   = 32'h0;
    logic [15:0] ptr     = 16'h0;
    logic [31:0] irVal   = 32'h0;
    logic        irInc   = 1'b0;
    logic        irDec   = 1'b0;
    logic        irTwo   = 1'b0;
    logic [31:0] prdata, irNext, rd, irSeen;
    logic        pready, pslverr, instrExec, halt, insErr, accErr, irq, err;
    logic [12:0] evt;
    logic [31:0] hb [0:5] = '{32'h4000, 32'h8000, 32'h0800, 32'h1000, 32'h1000, 32'h1000};
    int          n_fail = 0;
    int          checks = 0;

    always #20 mclk = ~mclk;

    pek_engine_model u_eng (.mclk(mclk), .rst(rst), .haltExec(halt), .fire(fire), .code(code),
        .instrExec(instrExec), .evt(evt));

    pek_error_recorder #(.IR_WIDTH(32), .DIFF_MAX(DMAX)) u_dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .instrExec(instrExec), .operandErr(evt[0]), .paramAreaAccess(evt[1]),
        .uninstalledWrite(evt[2]), .fileBankAccess(evt[3]), .readOnlyWrite(evt[4]),
        .indirectUse(evt[5]), .pointerWord(ptr), .illegalInstr(evt[6]), .umOverflow(evt[7]),
        .noEndInstr(evt[8]), .noCyclicTask(evt[9]), .taskNoProgram(evt[10]),
        .missingIntTask(evt[11]), .diffEdit(evt[12]), .taskIsInterrupt(isInt), .taskIndex(tIdx),
        .programAddr(pAddr), .irValue(irVal), .irInc(irInc), .irDec(irDec), .irStepTwo(irTwo),
        .irNext(irNext), .haltExec(halt), .instructionErrorFlag(insErr),
        .accessErrorFlag(accErr), .irq(irq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Entered just after an edge; leaves one idle cycle so psel is never set twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    // Engine pulses in the second cycle; irNext taken at the edge ending it
    task automatic pulse(input logic [3:0] c);
        code <= c;
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
        @(posedge mclk);
        irSeen = irNext;
        @(posedge mclk);
    endtask : pulse

    // Clear sticky state, then resume and set control in one write
    task automatic clr(input logic [31:0] ctl);
        apb(1'b1, pek_pkg::OFS_FAULT_STATUS, 32'hFFFF);
        apb(1'b1, pek_pkg::OFS_FLAGS, 32'h3);
        apb(1'b1, pek_pkg::OFS_CONTROL, ctl | 32'h8);
    endtask : clr

    task automatic close_out;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    initial begin
        #2000000;
        n_fail++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 8; i++) rdchk(8'(i * 4), 32'h0);
        apb(1'b1, 8'h20, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        rdchk(8'h20, 32'h0);
        apb(1'b1, pek_pkg::OFS_STOPPED_TASK, 32'hFFFF);
        rdchk(pek_pkg::OFS_STOPPED_TASK, 32'h0);
        $display("register map test done");
        tIdx  <= 8'h1F;
        pAddr <= 32'h1234_5678;
        irVal <= 32'h10;
        irInc <= 1'b1;
        irTwo <= 1'b1;
        pulse(4'h0);
        chk(irSeen, 32'h12);
        chk({31'h0, insErr}, 32'h1);
        chk({31'h0, halt}, 32'h0);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h0);
        rdchk(pek_pkg::OFS_FLAGS, 32'h1);
        irInc <= 1'b0;
        irDec <= 1'b1;
        irTwo <= 1'b0;
        apb(1'b1, pek_pkg::OFS_CONTROL, 32'h1);
        pulse(4'h0);
        chk(irSeen, 32'hF);
        chk({31'h0, halt}, 32'h1);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h100);
        rdchk(pek_pkg::OFS_STOPPED_TASK, 32'h1F);
        rdchk(pek_pkg::OFS_ADDR_LOW, 32'h5678);
        rdchk(pek_pkg::OFS_ADDR_HIGH, 32'h1234);
        clr(32'h2);
        chk({31'h0, halt}, 32'h0);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h0);
        $display("operand error test done");
        isInt <= 1'b1;
        tIdx  <= 8'hFF;
        for (int c = 1; c < 5; c++) begin
            pulse(4'(c));
            chk({31'h0, accErr}, 32'h1);
            chk({31'h0, halt}, 32'h1);
            rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h600);
            rdchk(pek_pkg::OFS_STOPPED_TASK, 32'h80FF);
            clr(32'h2);
        end
        clr(32'h0);
        pulse(4'h4);
        chk({31'h0, accErr}, 32'h1);
        chk({31'h0, halt}, 32'h0);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h0);
        $display("access error test done");
        clr(32'h0);
        ptr <= 16'h12A4;
        pulse(4'h5);
        chk({31'h0, accErr}, 32'h0);
        clr(32'h4);
        pulse(4'h5);
        chk({31'h0, accErr}, 32'h1);
        chk({31'h0, halt}, 32'h0);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h200);
        clr(32'h6);
        pulse(4'h5);
        chk({31'h0, halt}, 32'h1);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h600);
        clr(32'h4);
        ptr <= 16'h9999;
        pulse(4'h5);
        chk({31'h0, accErr}, 32'h0);
        $display("indirect pointer test done");
        isInt <= 1'b0;
        tIdx  <= 8'h03;
        for (int k = 0; k < 6; k++) begin
            clr(32'h0);
            pAddr <= 32'hC0DE_0000 + 32'(k);
            pulse(4'(6 + k));
            chk({31'h0, halt}, 32'h1);
            rdchk(pek_pkg::OFS_FAULT_STATUS, hb[k]);
            rdchk(pek_pkg::OFS_ADDR_LOW, 32'(k));
        end
        rdchk(pek_pkg::OFS_STOPPED_TASK, 32'h3);
        pAddr <= 32'h0000_7777;
        pulse(4'h6);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h5000);
        rdchk(pek_pkg::OFS_ADDR_LOW, 32'h5);
        $display("halting error test done");
        clr(32'h0);
        for (int i = 0; i < DMAX; i++) pulse(4'hC);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h0);
        rdchk(pek_pkg::OFS_DIFF_COUNT, 32'(DMAX));
        pulse(4'hC);
        rdchk(pek_pkg::OFS_FAULT_STATUS, 32'h2000);
        chk({31'h0, halt}, 32'h1);
        $display("edit overflow test done");
        clr(32'h0);
        apb(1'b1, pek_pkg::OFS_IRQ_MASK, 32'h8000);
        pulse(4'h6);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, pek_pkg::OFS_IRQ_MASK, 32'h4000);
        chk({31'h0, irq}, 32'h1);
        clr(32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        close_out();
    end
endmodule : test_program_error_recorder
`default_nettype wire
